// *** verilog/uif_pkg.sv ***
// constants for the uart interrupt identification and line format block
package uif_pkg;
	// ==========================================================
	// register byte addresses
	localparam logic [7:0] ADDR_LINE_FMT  = 8'h00;
	localparam logic [7:0] ADDR_FIFO_SET  = 8'h04;
	localparam logic [7:0] ADDR_ENH_CTL   = 8'h08;
	localparam logic [7:0] ADDR_RX_THR    = 8'h0C;
	localparam logic [7:0] ADDR_TX_THR    = 8'h10;
	localparam logic [7:0] ADDR_FLOW_LO   = 8'h14;
	localparam logic [7:0] ADDR_FLOW_HI   = 8'h18;
	localparam logic [7:0] ADDR_INT_ID    = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STAT  = 8'h20;
	localparam logic [7:0] ADDR_IRQ_MASK  = 8'h24;
	localparam logic [7:0] ADDR_FMT_STAT  = 8'h28;
	// ==========================================================
	// field positions
	localparam int LF_DIV_ACCESS = 7;
	localparam int LF_BREAK      = 6;
	localparam int LF_PAR_LO     = 3;
	localparam int LF_STOP       = 2;
	localparam int FS_ENABLE     = 0;
	localparam int FS_TX_LO      = 4;
	localparam int FS_RX_LO      = 6;
	localparam int EF_ENHANCED   = 4;
	// ==========================================================
	// reset values
	localparam logic [7:0] LINE_FMT_RST = 8'h00;
	localparam logic [7:0] FIFO_SET_RST = 8'h00;
	localparam logic [7:0] BYTE_RST     = 8'h00;
	localparam logic [6:0] MASK_RST     = 7'h00;
	// ==========================================================
	// interrupt sources, highest priority first
	localparam int NSRC       = 7;
	localparam int SRC_LINE   = 0;
	localparam int SRC_RXDATA = 1;
	localparam int SRC_RXTMO  = 2;
	localparam int SRC_TXEMP  = 3;
	localparam int SRC_MODEM  = 4;
	localparam int SRC_XOFF   = 5;
	localparam int SRC_FLOW   = 6;
	localparam logic [5:0] CODE_LINE   = 6'h06;
	localparam logic [5:0] CODE_RXDATA = 6'h04;
	localparam logic [5:0] CODE_RXTMO  = 6'h0C;
	localparam logic [5:0] CODE_TXEMP  = 6'h02;
	localparam logic [5:0] CODE_MODEM  = 6'h00;
	localparam logic [5:0] CODE_XOFF   = 6'h10;
	localparam logic [5:0] CODE_FLOW   = 6'h20;
	localparam logic [5:0] CODE_NONE   = 6'h01;
	// ==========================================================
	// trigger levels in bytes
	localparam logic [7:0] RX_LVL_00 = 8'h08;
	localparam logic [7:0] RX_LVL_01 = 8'h10;
	localparam logic [7:0] RX_LVL_10 = 8'h18;
	localparam logic [7:0] RX_LVL_11 = 8'h1C;
	localparam logic [7:0] TX_LVL_00 = 8'h10;
	localparam logic [7:0] TX_LVL_01 = 8'h08;
	localparam logic [7:0] TX_LVL_10 = 8'h18;
	localparam logic [7:0] TX_LVL_11 = 8'h1E;
	// ==========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		PAR_NONE   = 3'h0,
		PAR_ODD    = 3'h1,
		PAR_EVEN   = 3'h3,
		PAR_FORCE1 = 3'h2,
		PAR_FORCE0 = 3'h6
	} uif_parity_t;
endpackage

// *** verilog/uif_core.sv ***
// uart interrupt identification, trigger levels and line format registers
//
// What this block does
// R1: rx trigger bits pick 8/16/24/28 bytes
// R2: tx trigger bits pick 16/8/24/30 bytes
// R3: nonzero extended level registers override trigger bits
// R4: identification reads highest of seven priority levels
// R5: reported source held until serviced
// R6: codes for line, rx data, timeout, tx
// R7: codes for modem, xoff, flow change
// R8: bit zero low while interrupt pending
// R9: bits seven, six show fifo enable
// R10: xoff and flow bits need enhanced enable
// R11: xoff bit stays until xon received
// R12: format bit seven opens divisor access
// R13: break bit holds serial output low
// R14: parity selection from format bits 5:3
// R15: stop bit length from bit two
// R16: word length five to eight bits
// R17: fifo enable selects fifo operation
// R18: interrupt output follows pending indication
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module uif_core
	import uif_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	input  wire logic        i_ev_line_err,
	input  wire logic        i_ev_rx_data,
	input  wire logic        i_ev_rx_timeout,
	input  wire logic        i_ev_tx_empty,
	input  wire logic        i_ev_modem,
	input  wire logic        i_ev_xoff,
	input  wire logic        i_ev_xon,
	input  wire logic        i_ev_flow,
	output logic [7:0]       o_rx_threshold,
	output logic [7:0]       o_tx_threshold,
	output logic             o_fifo_enable,
	output logic             o_divisor_access,
	output logic             o_tx_break,
	output logic [2:0]       o_parity_mode,
	output logic [2:0]       o_stop_half_bits,
	output logic [3:0]       o_word_bits,
	output logic             o_irq
);
	// ==========================================================
	// helper functions
	function automatic logic [7:0] rx_level(input logic [1:0] sel);
		case (sel)
			2'h0: rx_level = RX_LVL_00;
			2'h1: rx_level = RX_LVL_01;
			2'h2: rx_level = RX_LVL_10;
			default: rx_level = RX_LVL_11;
		endcase
	endfunction
	function automatic logic [7:0] tx_level(input logic [1:0] sel);
		case (sel)
			2'h0: tx_level = TX_LVL_00;
			2'h1: tx_level = TX_LVL_01;
			2'h2: tx_level = TX_LVL_10;
			default: tx_level = TX_LVL_11;
		endcase
	endfunction
	function automatic logic [5:0] src_code(input logic [2:0] idx);
		case (idx)
			3'h0: src_code = CODE_LINE;
			3'h1: src_code = CODE_RXDATA;
			3'h2: src_code = CODE_RXTMO;
			3'h3: src_code = CODE_TXEMP;
			3'h4: src_code = CODE_MODEM;
			3'h5: src_code = CODE_XOFF;
			default: src_code = CODE_FLOW;
		endcase
	endfunction
	function automatic logic [2:0] top_src(input logic [NSRC-1:0] v);
		top_src = 3'h0;
		for (int k = NSRC - 1; k >= 0; k--) begin
			if (v[k]) begin
				top_src = 3'(k);
			end
		end
	endfunction

	// ==========================================================
	// register storage
	logic [7:0]      line_fmt_reg;
	logic [7:0]      fifo_set_reg;
	logic [7:0]      enh_ctl_reg;
	logic [7:0]      rx_thr_reg;
	logic [7:0]      tx_thr_reg;
	logic [7:0]      flow_lo_reg;
	logic [7:0]      flow_hi_reg;
	logic [NSRC-1:0] pend_reg;
	logic [NSRC-1:0] mask_reg;
	logic [2:0]      rep_reg;
	logic            hold_reg;

	// ==========================================================
	// axi write channel
	logic       aw_got_reg;
	logic       w_got_reg;
	logic [7:0] waddr_reg;
	logic [7:0] wbyte_reg;
	logic       wlane_reg;
	logic       do_write;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_awready  <= 1'b0;
			o_wready   <= 1'b0;
			aw_got_reg <= 1'b0;
			w_got_reg  <= 1'b0;
			waddr_reg  <= 8'h00;
			wbyte_reg  <= 8'h00;
			wlane_reg  <= 1'b0;
		end else begin
			o_awready <= !aw_got_reg && !o_awready && !o_bvalid;
			o_wready  <= !w_got_reg && !o_wready && !o_bvalid;
			if (i_awvalid && o_awready) begin
				aw_got_reg <= 1'b1;
				waddr_reg  <= i_awaddr;
				o_awready  <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_got_reg <= 1'b1;
				wbyte_reg <= i_wdata[7:0];
				wlane_reg <= i_wstrb[0];
				o_wready  <= 1'b0;
			end
			if (do_write) begin
				aw_got_reg <= 1'b0;
				w_got_reg  <= 1'b0;
			end
		end
	end
	assign do_write = aw_got_reg && w_got_reg && !o_bvalid;
	logic addr_ok_w;
	assign addr_ok_w = (waddr_reg[1:0] == 2'h0) &&
		(waddr_reg <= ADDR_FMT_STAT);
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			o_bresp  <= addr_ok_w ? RESP_OKAY : RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end
	logic wr_en;
	assign wr_en = do_write && wlane_reg;

	// ==========================================================
	// writable configuration registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			line_fmt_reg <= LINE_FMT_RST;
			fifo_set_reg <= FIFO_SET_RST;
			enh_ctl_reg  <= BYTE_RST;
			rx_thr_reg   <= BYTE_RST;
			tx_thr_reg   <= BYTE_RST;
			flow_lo_reg  <= BYTE_RST;
			flow_hi_reg  <= BYTE_RST;
			mask_reg     <= MASK_RST;
		end else if (wr_en) begin
			case (waddr_reg)
				ADDR_LINE_FMT: line_fmt_reg <= wbyte_reg;
				ADDR_FIFO_SET: fifo_set_reg <= wbyte_reg;
				ADDR_ENH_CTL:  enh_ctl_reg  <= wbyte_reg;
				ADDR_RX_THR:   rx_thr_reg   <= wbyte_reg;
				ADDR_TX_THR:   tx_thr_reg   <= wbyte_reg;
				ADDR_FLOW_LO:  flow_lo_reg  <= wbyte_reg;
				ADDR_FLOW_HI:  flow_hi_reg  <= wbyte_reg;
				ADDR_IRQ_MASK: mask_reg     <= wbyte_reg[NSRC-1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// interrupt sources
	logic [NSRC-1:0] ev_vec;
	logic [NSRC-1:0] clr_vec;
	logic            enh_on;
	assign enh_on = enh_ctl_reg[EF_ENHANCED];
	assign ev_vec = {i_ev_flow, i_ev_xoff, i_ev_modem, i_ev_tx_empty,
		i_ev_rx_timeout, i_ev_rx_data, i_ev_line_err};
	always_comb begin
		clr_vec = '0;
		if (wr_en && waddr_reg == ADDR_IRQ_STAT) begin
			clr_vec = wbyte_reg[NSRC-1:0];
		end
		clr_vec[SRC_XOFF] = i_ev_xon; // [R11]
	end
	// set beats clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pend_reg <= '0;
		end else begin
			pend_reg <= (pend_reg & ~clr_vec) | ev_vec;
		end
	end
	logic [NSRC-1:0] active;
	always_comb begin
		active = pend_reg & mask_reg;
		if (!enh_on) begin
			active[SRC_XOFF] = 1'b0; // [R10]
			active[SRC_FLOW] = 1'b0; // [R10]
		end
	end

	// ==========================================================
	// interrupt identification
	logic       any_act;
	logic [2:0] cur_src;
	logic [7:0] int_id;
	logic       id_read;
	assign any_act = |active;
	// hold last reported source while it is still pending
	assign cur_src = (hold_reg && active[rep_reg]) ?
		rep_reg : top_src(active); // [R4] [R5]
	always_comb begin
		int_id[7:6] = {2{fifo_set_reg[FS_ENABLE]}}; // [R9] [R17]
		int_id[5:0] = any_act ? src_code(cur_src) : CODE_NONE; // [R6] [R7] [R8]
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hold_reg <= 1'b0;
			rep_reg  <= 3'h0;
		end else if (id_read && any_act) begin
			hold_reg <= 1'b1; // [R5]
			rep_reg  <= cur_src;
		end else if (!active[rep_reg]) begin
			hold_reg <= 1'b0; // [R5]
		end
	end

	// ==========================================================
	// trigger levels and line format
	logic       ext_levels;
	logic [7:0] rx_lvl_next;
	logic [7:0] tx_lvl_next;
	logic [2:0] par_next;
	logic [2:0] stop_next;
	assign ext_levels = |{rx_thr_reg, tx_thr_reg, flow_lo_reg, flow_hi_reg};
	assign rx_lvl_next = ext_levels ? rx_thr_reg :
		rx_level(fifo_set_reg[FS_RX_LO +: 2]); // [R1] [R3]
	assign tx_lvl_next = ext_levels ? tx_thr_reg :
		tx_level(fifo_set_reg[FS_TX_LO +: 2]); // [R2] [R3]
	always_comb begin
		case (line_fmt_reg[LF_PAR_LO +: 3])
			3'b011:  par_next = PAR_EVEN; // [R14]
			3'b001:  par_next = PAR_FORCE1; // [R14]
			3'b101:  par_next = PAR_ODD; // [R14]
			3'b111:  par_next = PAR_FORCE0; // [R14]
			default: par_next = PAR_NONE; // [R14]
		endcase
		if (!line_fmt_reg[LF_STOP]) begin
			stop_next = 3'h2; // [R15]
		end else if (line_fmt_reg[1:0] == 2'h0) begin
			stop_next = 3'h3; // [R15]
		end else begin
			stop_next = 3'h4; // [R15]
		end
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rx_threshold   <= RX_LVL_00;
			o_tx_threshold   <= TX_LVL_00;
			o_fifo_enable    <= 1'b0;
			o_divisor_access <= 1'b0;
			o_tx_break       <= 1'b0;
			o_parity_mode    <= PAR_NONE;
			o_stop_half_bits <= 3'h2;
			o_word_bits      <= 4'h5;
			o_irq            <= 1'b0;
		end else begin
			o_rx_threshold   <= rx_lvl_next;
			o_tx_threshold   <= tx_lvl_next;
			o_fifo_enable    <= fifo_set_reg[FS_ENABLE]; // [R17]
			o_divisor_access <= line_fmt_reg[LF_DIV_ACCESS]; // [R12]
			o_tx_break       <= line_fmt_reg[LF_BREAK]; // [R13]
			o_parity_mode    <= par_next;
			o_stop_half_bits <= stop_next;
			o_word_bits      <= 4'h5 + {2'h0, line_fmt_reg[1:0]}; // [R16]
			o_irq            <= any_act; // [R18]
		end
	end

	// ==========================================================
	// axi read channel
	logic [31:0] rd_next;
	logic        rd_ok;
	always_comb begin
		rd_next = 32'h0000_0000;
		rd_ok   = 1'b1;
		case (i_araddr)
			ADDR_LINE_FMT: rd_next[7:0] = line_fmt_reg;
			ADDR_FIFO_SET: rd_next[7:0] = fifo_set_reg;
			ADDR_ENH_CTL:  rd_next[7:0] = enh_ctl_reg;
			ADDR_RX_THR:   rd_next[7:0] = rx_thr_reg;
			ADDR_TX_THR:   rd_next[7:0] = tx_thr_reg;
			ADDR_FLOW_LO:  rd_next[7:0] = flow_lo_reg;
			ADDR_FLOW_HI:  rd_next[7:0] = flow_hi_reg;
			ADDR_INT_ID:   rd_next[7:0] = int_id;
			ADDR_IRQ_STAT: rd_next[NSRC-1:0] = pend_reg;
			ADDR_IRQ_MASK: rd_next[NSRC-1:0] = mask_reg;
			ADDR_FMT_STAT: rd_next = {4'h0, o_word_bits, 1'b0,
				o_stop_half_bits, 1'b0, o_parity_mode,
				o_tx_threshold, o_rx_threshold};
			default:       rd_ok = 1'b0;
		endcase
	end
	assign id_read = i_arvalid && o_arready && i_araddr == ADDR_INT_ID;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h0000_0000;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !o_arready;
			if (i_arvalid && o_arready) begin
				o_arready <= 1'b0;
				o_rvalid  <= 1'b1;
				o_rdata   <= rd_next;
				o_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	chk_rx_table: assert property ( // [R1]
		!ext_levels && $past(!ext_levels) && fifo_set_reg[7:6] == 2'h3 &&
		$stable(fifo_set_reg) |-> o_rx_threshold == 8'h1C)
		else $error("rx trigger level wrong");
	chk_tx_table: assert property ( // [R2]
		!ext_levels && $past(!ext_levels) && fifo_set_reg[5:4] == 2'h1 &&
		$stable(fifo_set_reg) |-> o_tx_threshold == 8'h08)
		else $error("tx trigger level wrong");
	chk_ext_override: assert property ( // [R3]
		ext_levels |=> o_rx_threshold == $past(rx_thr_reg) &&
		o_tx_threshold == $past(tx_thr_reg))
		else $error("extended levels not used");
	chk_top_first: assert property ( // [R4]
		!hold_reg && active[SRC_LINE] |-> int_id[5:0] == 6'h06)
		else $error("line error not reported first");
	chk_hold_report: assert property ( // [R5]
		id_read && any_act ##1 active[$past(cur_src)] |->
		cur_src == $past(cur_src))
		else $error("reported source changed before service");
	chk_timeout_code: assert property ( // [R6]
		any_act && cur_src == 3'h2 |-> int_id[5:0] == 6'h0C)
		else $error("timeout code wrong");
	chk_no_pending: assert property ( // [R8]
		int_id[0] == !any_act)
		else $error("pending flag wrong");
	chk_fifo_bits: assert property ( // [R9]
		int_id[7] == fifo_set_reg[0] && int_id[6] == fifo_set_reg[0])
		else $error("fifo enabled bits wrong");
	chk_enh_gate: assert property ( // [R10]
		!enh_on |-> int_id[5:4] == 2'h0)
		else $error("enhanced bits shown while disabled");
	chk_xoff_sticky: assert property ( // [R11]
		pend_reg[SRC_XOFF] && !i_ev_xon |=> pend_reg[SRC_XOFF])
		else $error("xoff cleared without xon");
	chk_break_out: assert property ( // [R13]
		line_fmt_reg[6] ##1 line_fmt_reg[6] |-> o_tx_break)
		else $error("break not held");
	chk_irq_follow: assert property ( // [R18]
		any_act |=> o_irq)
		else $error("irq output missing");
	cov_xoff_xon: cover property (pend_reg[SRC_XOFF] ##[1:20] i_ev_xon);
	cov_held_read: cover property (id_read && any_act ##1 hold_reg);
	cov_slverr: cover property (o_rvalid && o_rresp == RESP_SLVERR);
endmodule
`default_nettype wire

// *** test/uif_host.sv ***
// host cpu model speaking axi4-lite to the block's register port
`timescale 1ns/1ps
`default_nettype none
module uif_host (
	input  wire logic        i_clk,
	output logic [7:0]       o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [31:0]      o_wdata,
	output logic [3:0]       o_wstrb,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	output logic [7:0]       o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	initial begin
		{o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid} = '0;
		{o_bready, o_araddr, o_arvalid, o_rready} = '0;
	end
	// ==========================================================
	// write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [7:0] v,
			output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge i_clk);
		o_awaddr <= a;
		o_wdata <= {24'h000000, v};
		o_wstrb <= 4'h1;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge i_clk);
			if (o_awvalid && i_awready) begin
				aw_done = 1'b1;
				o_awvalid <= 1'b0;
			end
			if (o_wvalid && i_wready) begin
				w_done = 1'b1;
				o_wvalid <= 1'b0;
			end
		end
		do @(posedge i_clk); while (i_bvalid !== 1'b1);
		r = i_bresp;
		o_bready <= 1'b0;
	endtask
	// ==========================================================
	// read: address held until taken, rready held until data comes
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		@(posedge i_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		do @(posedge i_clk); while (i_arready !== 1'b1);
		o_arvalid <= 1'b0;
		o_rready <= 1'b1;
		do @(posedge i_clk); while (i_rvalid !== 1'b1);
		d = i_rdata;
		r = i_rresp;
		o_rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// *** test/uif_core_tb.sv ***
// self-checking bench for the identification and line format block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
	miscompares++; $display("[ERR] %s expected %h seen %h", n, e, g); end end
module uif_core_tb
	import uif_pkg::*;
;
	logic        i_clk, i_rst, awvalid, awready, wvalid, wready, bvalid;
	logic        bready, arvalid, arready, rvalid, rready, fifo_en, irq;
	logic        div_acc, brk;
	logic [7:0]  ev, awaddr, araddr, rx_thr, tx_thr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, wbits;
	logic [1:0]  bresp, rresp, r;
	logic [2:0]  par, stp, pe;
	int          miscompares, compares, cycles;
	localparam logic [7:0] RXT [4] = '{8'h08, 8'h10, 8'h18, 8'h1C};
	localparam logic [7:0] TXT [4] = '{8'h10, 8'h08, 8'h18, 8'h1E};
	localparam logic [5:0] CODES [7] = '{6'h06, 6'h04, 6'h0C, 6'h02,
		6'h00, 6'h10, 6'h20};
	uif_host uif_host_i (.i_clk(i_clk), .o_awaddr(awaddr),
		.o_awvalid(awvalid), .i_awready(awready), .o_wdata(wdata),
		.o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
		.i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .i_arready(arready),
		.i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
		.o_rready(rready));
	uif_core uif_core_i (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_ev_line_err(ev[0]), .i_ev_rx_data(ev[1]),
		.i_ev_rx_timeout(ev[2]), .i_ev_tx_empty(ev[3]),
		.i_ev_modem(ev[4]), .i_ev_xoff(ev[5]), .i_ev_flow(ev[6]),
		.i_ev_xon(ev[7]), .o_rx_threshold(rx_thr),
		.o_tx_threshold(tx_thr), .o_fifo_enable(fifo_en),
		.o_divisor_access(div_acc), .o_tx_break(brk),
		.o_parity_mode(par), .o_stop_half_bits(stp),
		.o_word_bits(wbits), .o_irq(irq));
	// ==========================================================
	// clock, timeout and verdict
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ==========================================================
	// access helpers; outputs are looked at once the write has settled
	task automatic wrt(input logic [7:0] a, input logic [7:0] v);
		uif_host_i.wr(a, v, r);
		`CHK("bresp", RESP_OKAY, r)
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	task automatic rdc(input string n, input logic [7:0] a,
			input logic [31:0] e);
		uif_host_i.rd(a, d, r);
		`CHK(n, e, d)
		#1;
	endtask
	task automatic pulse(input logic [7:0] m);
		@(posedge i_clk);
		ev <= m;
		@(posedge i_clk);
		ev <= 8'h00;
		repeat (2) @(posedge i_clk);
		#1;
	endtask
	// ==========================================================
	// main sequence
	initial begin
		i_rst = 1'b1;
		ev = 8'h00;
		miscompares = 0;
		compares = 0;
		cycles = 0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		`CHK("irq", 1'b0, irq)
		rdc("id", ADDR_INT_ID, 32'h01);
		rdc("fmt", ADDR_FMT_STAT, 32'h05201008);
		rdc("lf", ADDR_LINE_FMT, 32'h0);
		uif_host_i.rd(8'h2C, d, r);
		`CHK("rresp", RESP_SLVERR, r)
		uif_host_i.wr(8'h30, 8'h11, r);
		`CHK("bresp", RESP_SLVERR, r)
		for (int i = 0; i < 4; i++) begin
			wrt(ADDR_FIFO_SET, {i[1:0], i[1:0], 4'h1});
			`CHK("rx thr", RXT[i], rx_thr)
			`CHK("tx thr", TXT[i], tx_thr)
		end
		`CHK("fifo en", 1'b1, fifo_en)
		rdc("id", ADDR_INT_ID, 32'hC1);
		wrt(ADDR_RX_THR, 8'h05);
		wrt(ADDR_TX_THR, 8'h07);
		`CHK("rx thr", 8'h05, rx_thr)
		`CHK("tx thr", 8'h07, tx_thr)
		wrt(ADDR_RX_THR, 8'h00);
		wrt(ADDR_TX_THR, 8'h00);
		wrt(ADDR_FLOW_LO, 8'h03);
		`CHK("rx thr", 8'h00, rx_thr)
		wrt(ADDR_FLOW_LO, 8'h00);
		wrt(ADDR_FLOW_HI, 8'h09);
		`CHK("tx thr", 8'h00, tx_thr)
		wrt(ADDR_FLOW_HI, 8'h00);
		`CHK("rx thr", 8'h1C, rx_thr)
		for (int v = 0; v < 256; v++) begin
			wrt(ADDR_LINE_FMT, v[7:0]);
			pe = !v[3] ? 3'h0 : !v[4] ? (v[5] ? 3'h1 : 3'h2)
				: (v[5] ? 3'h6 : 3'h3);
			`CHK("word", 4'h5 + {2'b00, v[1:0]}, wbits)
			`CHK("stop", !v[2] ? 3'h2 : (v[1:0] == 2'b00 ? 3'h3 : 3'h4),
				stp)
			`CHK("parity", pe, par)
			`CHK("div", v[7], div_acc)
			`CHK("break", v[6], brk)
			rdc("lf", ADDR_LINE_FMT, v);
		end
		wrt(ADDR_LINE_FMT, 8'h00);
		pulse(8'h08);
		`CHK("irq", 1'b0, irq)
		wrt(ADDR_IRQ_MASK, 8'h7F);
		`CHK("irq", 1'b1, irq)
		rdc("id", ADDR_INT_ID, 32'hC2);
		pulse(8'h02);
		rdc("id", ADDR_INT_ID, 32'hC2);
		wrt(ADDR_IRQ_STAT, 8'h08);
		rdc("id", ADDR_INT_ID, 32'hC4);
		wrt(ADDR_IRQ_STAT, 8'h02);
		rdc("id", ADDR_INT_ID, 32'hC1);
		`CHK("irq", 1'b0, irq)
		pulse(8'h60);
		rdc("id", ADDR_INT_ID, 32'hC1);
		`CHK("irq", 1'b0, irq)
		pulse(8'h80);
		wrt(ADDR_IRQ_STAT, 8'h60);
		wrt(ADDR_LINE_FMT, 8'h80);
		wrt(ADDR_ENH_CTL, 8'h10);
		wrt(ADDR_LINE_FMT, 8'h00);
		pulse(8'h7F);
		`CHK("irq", 1'b1, irq)
		rdc("stat", ADDR_IRQ_STAT, 32'h7F);
		for (int k = 0; k < 7; k++) begin
			rdc("id", ADDR_INT_ID, {24'h0, 2'b11, CODES[k]});
			if (k == 5) begin
				wrt(ADDR_IRQ_STAT, 8'h20);
				rdc("id", ADDR_INT_ID, 32'hD0);
				pulse(8'h80);
			end else begin
				wrt(ADDR_IRQ_STAT, 8'h01 << k);
			end
		end
		rdc("id", ADDR_INT_ID, 32'hC1);
		`CHK("irq", 1'b0, irq)
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		#1;
		`CHK("fifo en", 1'b0, fifo_en)
		`CHK("rx thr", 8'h08, rx_thr)
		rdc("id", ADDR_INT_ID, 32'h01);
		close_out();
	end
endmodule
`undef CHK
`default_nettype wire
